// *** hdl/mci_top.sv ***
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
// Operation
// - commands are quick, 7-bit, 32-bit or read; no read format is decoded, such opcodes count as unsupported
// - same handling whatever host interface delivered
// - keep input state; value 2 is halt
// - 0xE0 sets target position in host mode
// - 0xE3 sets clamped target velocity in host
// - 0xEC halts, loads position, clears uncertain
// - 0x89 halts abruptly, marks position uncertain
// - 0x8C restarts command timeout when enabled
// - 0x86 disables driver, sets de-energize error
// - de-energized error lights LED, raises error
// - 0x85 clears de-energize, requests driver on
// - energize leaves position uncertain flag set
// - 0x83 in host suppresses safe start 200ms
// - 0x8F in listed modes sets safe start
// - otherwise 0x8F only pulses soft stop
// - speed modes clear safe start at neutral
module mci_top #(
  parameter int SAFE_HOLD_CYC = mci_pkg::SAFE_HOLD_CYC,
  parameter int CMD_TIMEOUT_CYC = mci_pkg::CMD_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // motion side
  input wire logic input_neutral,
  output logic [31:0] target_pos,
  output logic [31:0] target_vel,
  output logic [31:0] cur_pos,
  output logic [2:0] input_state,
  output logic pos_uncertain,
  output logic driver_en,
  output logic motion_ok,
  output logic halt_abrupt,
  output logic soft_stop,
  // indicators
  output logic err_line,
  output logic red_led,
  output logic irq
);

  // ****************************************
  // bus handshake
  // ****************************************
  // one wait state: the request is taken on the edge where done is high
  logic done;
  logic [31:0] data_reg;
  logic [31:0] ctrl;
  logic [31:0] scaled;
  logic [7:0] last_op;
  logic err_deen;
  logic err_safe;
  logic err_tmo;
  logic [mci_pkg::IRQ_W-1:0] irq_stat;
  logic [mci_pkg::IRQ_W-1:0] irq_mask;

  wire req = avs_read | avs_write;
  wire take = req & done;
  wire wr_take = avs_write & done;
  wire rd_take = avs_read & done;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= req & ~done;
    end
  end

  assign avs_waitrequest = req & ~done;

  // ****************************************
  // decode
  // ****************************************
  wire hit_cmd = avs_address == mci_pkg::ADDR_CMD;
  wire hit_data = avs_address == mci_pkg::ADDR_DATA;
  wire hit_ctrl = avs_address == mci_pkg::ADDR_CTRL;
  wire hit_istat = avs_address == mci_pkg::ADDR_IRQ_STAT;
  wire hit_imask = avs_address == mci_pkg::ADDR_IRQ_MASK;

  // every host interface funnels into this single command port
  wire cmd_fire = wr_take & hit_cmd & avs_byteenable[0];
  wire [7:0] op = avs_writedata[7:0];
  mci_pkg::mci_fmt_t fmt;
  assign fmt = mci_pkg::mci_fmt_of(op);
  wire unsupported = cmd_fire & (fmt == mci_pkg::FMT_NONE);

  wire [2:0] mode = ctrl[mci_pkg::CTRL_MODE_LSB +: 3];
  wire safe_en = ctrl[mci_pkg::CTRL_SAFE_EN];
  wire tmo_en = ctrl[mci_pkg::CTRL_TMO_EN];
  wire host = mode == mci_pkg::MODE_HOST;
  wire speed_mode = (mode == mci_pkg::MODE_RC_SPD) | (mode == mci_pkg::MODE_AN_SPD) |
                    (mode == mci_pkg::MODE_ENC_SPD);

  // non-host modes drop motion commands; only last_op records them
  wire do_pos = cmd_fire & (op == mci_pkg::OP_TGT_POS) & host;
  wire do_vel = cmd_fire & (op == mci_pkg::OP_TGT_VEL) & host;
  wire do_hset = cmd_fire & (op == mci_pkg::OP_HALT_SET) & host;
  wire do_hold = cmd_fire & (op == mci_pkg::OP_HALT_HOLD) & host;
  wire do_tmo = cmd_fire & (op == mci_pkg::OP_TMO_RST) & tmo_en;
  wire do_deen = cmd_fire & (op == mci_pkg::OP_DEENERGIZE);
  wire do_en = cmd_fire & (op == mci_pkg::OP_ENERGIZE);
  wire do_exit = cmd_fire & (op == mci_pkg::OP_EXIT_SAFE) & host;
  wire do_enter = cmd_fire & (op == mci_pkg::OP_ENTER_SAFE);
  wire enter_latch = do_enter & safe_en & (host | speed_mode);

  // velocity beyond the legal range is clamped, not rejected
  wire signed [31:0] vel_in = data_reg;
  wire [31:0] vel_clamped = (vel_in > mci_pkg::VEL_MAX) ? mci_pkg::VEL_MAX :
                            (vel_in < -mci_pkg::VEL_MAX) ? -mci_pkg::VEL_MAX : data_reg;

  // ****************************************
  // timers
  // ****************************************
  logic safe_hold;
  logic safe_expire;
  logic tmo_expire;
  logic tmo_run;

  mci_timer u_safe_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(do_exit),
    .cancel(enter_latch),
    .period(32'(SAFE_HOLD_CYC)),
    .active(safe_hold),
    .expire(safe_expire)
  );

  mci_timer u_tmo_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(do_tmo | (tmo_en & ~tmo_run)),
    .cancel(~tmo_en),
    .period(32'(CMD_TIMEOUT_CYC)),
    .active(tmo_run),
    .expire(tmo_expire)
  );

  // ****************************************
  // command state
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_reg <= 32'h0000_0000;
      ctrl <= mci_pkg::CTRL_RESET;
      last_op <= 8'h00;
    end else begin
      if (wr_take & hit_data) begin
        data_reg <= mci_pkg::mci_merge(data_reg, avs_writedata, avs_byteenable);
      end
      if (wr_take & hit_ctrl) begin
        ctrl <= mci_pkg::mci_merge(ctrl, avs_writedata, avs_byteenable) & mci_pkg::CTRL_MASK;
      end
      if (cmd_fire) begin
        last_op <= op;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      target_pos <= 32'h0000_0000;
      target_vel <= 32'h0000_0000;
      cur_pos <= 32'h0000_0000;
      scaled <= 32'h0000_0000;
      input_state <= mci_pkg::IN_NOT_READY;
    end else begin
      if (do_pos) begin
        target_pos <= data_reg;
        input_state <= mci_pkg::IN_TGT_POS;
      end
      if (do_vel) begin
        target_vel <= vel_clamped;
        input_state <= mci_pkg::IN_TGT_VEL;
      end
      if (do_hset | do_hold) begin
        input_state <= mci_pkg::IN_HALT;
        scaled <= 32'h0000_0000;
        target_vel <= 32'h0000_0000;
      end
      if (do_hset) begin
        cur_pos <= data_reg;
        target_pos <= data_reg;
      end
    end
  end

  // uncertain flag: only halt-and-set clears it; energize does not touch it
  wire next_pos_unc = do_hset ? 1'b0 : (pos_uncertain | do_hold | do_deen);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pos_uncertain <= 1'b1;
      driver_en <= 1'b1;
      err_deen <= 1'b0;
    end else begin
      pos_uncertain <= next_pos_unc;
      if (do_deen) begin
        driver_en <= 1'b0;
        err_deen <= 1'b1;
      end else if (do_en) begin
        driver_en <= 1'b1;
        err_deen <= 1'b0;
      end
    end
  end

  // ****************************************
  // safe start and timeout errors
  // ****************************************
  // set wins over every clear path
  wire safe_clear = safe_expire | (speed_mode & input_neutral);
  wire next_err_safe = enter_latch | (err_safe & ~safe_clear);
  wire next_err_tmo = tmo_expire | (err_tmo & ~do_tmo);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_safe <= 1'b0;
      err_tmo <= 1'b0;
    end else begin
      err_safe <= next_err_safe;
      err_tmo <= next_err_tmo;
    end
  end

  // during the hold window the latched violation is masked
  wire safe_eff = err_safe & ~safe_hold;
  wire any_err = err_deen | safe_eff | err_tmo;

  assign err_line = any_err;
  assign red_led = any_err;
  assign motion_ok = driver_en & ~any_err;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      halt_abrupt <= 1'b0;
      soft_stop <= 1'b0;
    end else begin
      halt_abrupt <= do_hset | do_hold | do_deen;
      soft_stop <= do_enter | tmo_expire;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  wire [mci_pkg::IRQ_W-1:0] irq_ev = {unsupported, tmo_expire, enter_latch, do_deen};
  wire [mci_pkg::IRQ_W-1:0] irq_w1c = (wr_take & hit_istat) ?
                                      avs_writedata[mci_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_w1c) | irq_ev;
      if (wr_take & hit_imask) begin
        irq_mask <= avs_writedata[mci_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // read mux
  // ****************************************
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[mci_pkg::ST_INSTATE_LSB +: 3] = input_state;
    status_word[mci_pkg::ST_POS_UNC] = pos_uncertain;
    status_word[mci_pkg::ST_DRV_EN] = driver_en;
    status_word[mci_pkg::ST_MOTION_OK] = motion_ok;
    status_word[mci_pkg::ST_ERR_DEEN] = err_deen;
    status_word[mci_pkg::ST_ERR_SAFE] = safe_eff;
    status_word[mci_pkg::ST_ERR_TMO] = err_tmo;
    status_word[mci_pkg::ST_LAST_OP_LSB +: 8] = last_op;
  end

  always_comb begin
    unique case (avs_address)
      mci_pkg::ADDR_CMD: rd_mux = {24'h00_0000, last_op};
      mci_pkg::ADDR_DATA: rd_mux = data_reg;
      mci_pkg::ADDR_CTRL: rd_mux = ctrl;
      mci_pkg::ADDR_STATUS: rd_mux = status_word;
      mci_pkg::ADDR_TGT_POS: rd_mux = target_pos;
      mci_pkg::ADDR_TGT_VEL: rd_mux = target_vel;
      mci_pkg::ADDR_CUR_POS: rd_mux = cur_pos;
      mci_pkg::ADDR_SCALED: rd_mux = scaled;
      mci_pkg::ADDR_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat};
      mci_pkg::ADDR_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~done) begin
      avs_readdata <= rd_mux;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_POS_HOST: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_fire && op == mci_pkg::OP_TGT_POS && !host) |=> $stable(target_pos))
    else $error("target position changed outside host mode");
  AST_VEL_LIMIT: assert property (@(posedge sys_clk) disable iff (rst)
    ($signed(target_vel) <= mci_pkg::VEL_MAX) && ($signed(target_vel) >= -mci_pkg::VEL_MAX))
    else $error("target velocity out of range");
  AST_HSET: assert property (@(posedge sys_clk) disable iff (rst)
    do_hset |=> (cur_pos == $past(data_reg)) && !pos_uncertain && input_state == 3'h2
                && scaled == 32'h0000_0000 && halt_abrupt)
    else $error("halt and set position incomplete");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    do_hold && !do_hset |=> pos_uncertain && input_state == 3'h2 && halt_abrupt)
    else $error("halt and hold incomplete");
  AST_DEEN: assert property (@(posedge sys_clk) disable iff (rst)
    do_deen |=> !driver_en && err_deen && pos_uncertain ##0 err_line)
    else $error("de-energize incomplete");
  AST_ERR_LINE: assert property (@(posedge sys_clk) disable iff (rst)
    err_deen |-> err_line && red_led)
    else $error("error line low while de-energized");
  AST_ENERGIZE: assert property (@(posedge sys_clk) disable iff (rst)
    do_en |=> driver_en && !err_deen && (motion_ok == !(safe_eff || err_tmo)))
    else $error("energize incomplete");
  AST_UNC_KEEP: assert property (@(posedge sys_clk) disable iff (rst)
    do_en && pos_uncertain && !do_hset |=> pos_uncertain)
    else $error("energize cleared uncertain flag");
  AST_EXIT_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    // a back-to-back 0x8f may cancel the hold from the fifth cycle on
    do_exit |=> (safe_hold && !safe_eff) [*4])
    else $error("safe start not suppressed after exit");
  AST_ENTER: assert property (@(posedge sys_clk) disable iff (rst)
    enter_latch |=> err_safe && soft_stop)
    else $error("enter safe start did not latch");
  AST_ENTER_NOP: assert property (@(posedge sys_clk) disable iff (rst)
    do_enter && !enter_latch && !err_safe |=> soft_stop && !err_safe)
    else $error("enter safe start had lasting effect");
  AST_NEUTRAL: assert property (@(posedge sys_clk) disable iff (rst)
    err_safe && speed_mode && input_neutral && !enter_latch |=> !err_safe)
    else $error("safe start kept at neutral");
  AST_TMO_RST: assert property (@(posedge sys_clk) disable iff (rst)
    do_tmo |=> !tmo_expire [*2])
    else $error("command timeout fired after refresh");
  AST_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");

endmodule

// *** hdl/mci_pkg.sv ***
package mci_pkg;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int SAFE_HOLD_MS = 200;
  localparam int SAFE_HOLD_CYC = SAFE_HOLD_MS * CYC_PER_MS;
  localparam int CMD_TIMEOUT_MS = 1000;
  localparam int CMD_TIMEOUT_CYC = CMD_TIMEOUT_MS * CYC_PER_MS;

  // ********************************
  // register map (byte addresses)
  // ********************************
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_TGT_POS = 8'h10;
  localparam logic [7:0] ADDR_TGT_VEL = 8'h14;
  localparam logic [7:0] ADDR_CUR_POS = 8'h18;
  localparam logic [7:0] ADDR_SCALED = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SAFE_EN = 4;
  localparam int CTRL_TMO_EN = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0037;

  // status fields
  localparam int ST_INSTATE_LSB = 0;
  localparam int ST_POS_UNC = 8;
  localparam int ST_DRV_EN = 9;
  localparam int ST_MOTION_OK = 10;
  localparam int ST_ERR_DEEN = 16;
  localparam int ST_ERR_SAFE = 17;
  localparam int ST_ERR_TMO = 18;
  localparam int ST_LAST_OP_LSB = 24;

  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DEEN = 0;
  localparam int IRQ_SAFE = 1;
  localparam int IRQ_TMO = 2;
  localparam int IRQ_UNSUP = 3;

  // ********************************
  // opcodes
  // ********************************
  localparam logic [7:0] OP_TGT_POS = 8'he0;
  localparam logic [7:0] OP_TGT_VEL = 8'he3;
  localparam logic [7:0] OP_HALT_SET = 8'hec;
  localparam logic [7:0] OP_HALT_HOLD = 8'h89;
  localparam logic [7:0] OP_TMO_RST = 8'h8c;
  localparam logic [7:0] OP_DEENERGIZE = 8'h86;
  localparam logic [7:0] OP_ENERGIZE = 8'h85;
  localparam logic [7:0] OP_EXIT_SAFE = 8'h83;
  localparam logic [7:0] OP_ENTER_SAFE = 8'h8f;
  localparam logic [7:0] OP_STEP_MODE = 8'h94;

  localparam logic signed [31:0] VEL_MAX = 32'sd500_000_000;

  // ********************************
  // input states and control modes
  // ********************************
  localparam logic [2:0] IN_NOT_READY = 3'h0;
  localparam logic [2:0] IN_HALT = 3'h2;
  localparam logic [2:0] IN_TGT_POS = 3'h3;
  localparam logic [2:0] IN_TGT_VEL = 3'h4;

  localparam logic [2:0] MODE_HOST = 3'h0;
  localparam logic [2:0] MODE_RC_SPD = 3'h2;
  localparam logic [2:0] MODE_AN_SPD = 3'h4;
  localparam logic [2:0] MODE_ENC_SPD = 3'h6;

  typedef enum logic [3:0] {
    FMT_NONE = 4'b0001,
    FMT_QUICK = 4'b0010,
    FMT_7BIT = 4'b0100,
    FMT_32BIT = 4'b1000
  } mci_fmt_t;

  function automatic mci_fmt_t mci_fmt_of(input logic [7:0] op);
    if (op == OP_TGT_POS || op == OP_TGT_VEL || op == OP_HALT_SET) begin
      return FMT_32BIT;
    end else if (op == OP_STEP_MODE) begin
      return FMT_7BIT;
    end else if (op == OP_HALT_HOLD || op == OP_TMO_RST || op == OP_DEENERGIZE ||
                 op == OP_ENERGIZE || op == OP_EXIT_SAFE || op == OP_ENTER_SAFE) begin
      return FMT_QUICK;
    end
    return FMT_NONE;
  endfunction

  function automatic logic [31:0] mci_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// *** hdl/mci_timer.sv ***
`timescale 1ns/1ps
module mci_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic cancel,
  input wire logic [31:0] period,
  // state
  output logic active,
  output logic expire
);

  logic [31:0] count;

  // restart wins over cancel, so a refresh never gets lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= 32'h0000_0000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        count <= period;
      end else if (cancel) begin
        count <= 32'h0000_0000;
      end else if (count != 32'h0000_0000) begin
        count <= count - 32'h0000_0001;
        expire <= (count == 32'h0000_0001);
      end
    end
  end

  assign active = (count != 32'h0000_0000);

endmodule

// *** bench/mci_host.sv ***
`timescale 1ns/1ps
module mci_host (
  // clock
  input wire logic sys_clk,
  // avalon-mm master side
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [3:0] avs_byteenable,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  logic hang;

  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    hang = 1'b0;
  end

  // ********************************
  // bus cycles
  // ********************************
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= ~rd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (avs_waitrequest !== 1'b0) begin
      hang = 1'b1;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data must not look like the last word
    avs_writedata <= ~d;
  endtask

  // payload first, opcode last: the opcode write triggers
  task automatic send(input logic [7:0] op, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b0, mci_pkg::ADDR_DATA, d, q);
    xfer(1'b0, mci_pkg::ADDR_CMD, {24'h0, op}, q);
  endtask
endmodule

// *** bench/motion_command_interpreter_tb.sv ***
`timescale 1ns/1ps
module motion_command_interpreter_tb;
  // ********************************
  // harness
  // ********************************
  localparam int HOLD = 20;
  localparam int TMO = 50;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic input_neutral = 1'b0;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, target_pos, target_vel, cur_pos, q;
  logic [2:0] input_state;
  logic avs_read, avs_write, avs_waitrequest, pos_uncertain, driver_en, motion_ok;
  logic halt_abrupt, soft_stop, err_line, red_led, irq;
  int fail_count = 0;
  int checked = 0;

  always #12.5 sys_clk = ~sys_clk;

  mci_host host (.sys_clk, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest);

  mci_top #(.SAFE_HOLD_CYC(HOLD), .CMD_TIMEOUT_CYC(TMO)) DUT (.sys_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .input_neutral, .target_pos, .target_vel, .cur_pos, .input_state, .pos_uncertain,
    .driver_en, .motion_ok, .halt_abrupt, .soft_stop, .err_line, .red_led, .irq);

  task automatic stop_test();
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic guard();
    if (host.hang) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b1, a, 32'h0, q);
    guard();
  endtask

  // both return mid-cycle after the taking edge, when effects are visible
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b0, a, d, q);
    guard();
    @(negedge sys_clk);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [31:0] d);
    host.send(op, d);
    guard();
    @(negedge sys_clk);
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset();
    rd(mci_pkg::ADDR_STATUS);
    chk(q, 32'h0000_0700);
    rd(8'h40);
    chk(q, 32'h0);
  endtask

  task automatic t_target();
    cmd(8'he0, 32'h8000_0001);
    cmd(8'he3, 32'h1dcd_6501);
    chk(target_pos, 32'h8000_0001);
    chk(target_vel, 32'h1dcd_6500);
    chk({29'h0, input_state}, 32'h4);
    cmd(8'he3, 32'he232_9aff);
    chk(target_vel, 32'he232_9b00);
    cmd(8'he0, 32'h7fff_ffff);
    chk(target_pos, 32'h7fff_ffff);
    chk({29'h0, input_state}, 32'h3);
  endtask

  task automatic t_halt();
    cmd(8'hec, 32'h0000_1234);
    chk1(halt_abrupt, 1'b1);
    chk(cur_pos, 32'h0000_1234);
    chk1(pos_uncertain, 1'b0);
    chk({29'h0, input_state}, 32'h2);
    rd(mci_pkg::ADDR_SCALED);
    chk(q, 32'h0);
    cmd(8'h89, 32'h0);
    chk1(halt_abrupt, 1'b1);
    chk1(pos_uncertain, 1'b1);
    cmd(8'hec, 32'h0);
    // rc speed mode: every host motion command is dropped
    wr(mci_pkg::ADDR_CTRL, 32'h0000_0012);
    cmd(8'he0, 32'h5);
    cmd(8'he3, 32'h5);
    cmd(8'h89, 32'h0);
    chk1(halt_abrupt, 1'b0);
    cmd(8'hec, 32'h9);
    chk1(halt_abrupt, 1'b0);
    chk(target_pos, 32'h0);
    chk(target_vel, 32'h0);
    chk(cur_pos, 32'h0);
    chk1(pos_uncertain, 1'b0);
    wr(mci_pkg::ADDR_CTRL, 32'h0000_0010);
  endtask

  task automatic t_deen();
    wr(mci_pkg::ADDR_IRQ_MASK, 32'h0);
    cmd(8'h86, 32'h0);
    chk({29'h0, halt_abrupt, driver_en, pos_uncertain}, 32'h5);
    chk({30'h0, err_line, red_led}, 32'h3);
    chk1(irq, 1'b0);
    rd(mci_pkg::ADDR_STATUS);
    chk(q & 32'h0001_0100, 32'h0001_0100);
    wr(mci_pkg::ADDR_IRQ_MASK, 32'h1);
    chk1(irq, 1'b1);
    wr(mci_pkg::ADDR_IRQ_STAT, 32'h1);
    chk1(irq, 1'b0);
    cmd(8'h85, 32'h0);
    chk({29'h0, driver_en, motion_ok, err_line}, 32'h6);
    chk1(pos_uncertain, 1'b1);
  endtask

  task automatic t_safe();
    cmd(8'h8f, 32'h0);
    chk({30'h0, soft_stop, err_line}, 32'h3);
    cmd(8'h86, 32'h0);
    cmd(8'h85, 32'h0);
    idle(HOLD);
    chk({30'h0, err_line, motion_ok}, 32'h2);
    rd(mci_pkg::ADDR_STATUS);
    chk(q & 32'h0003_0000, 32'h0002_0000);
    cmd(8'h83, 32'h0);
    chk({30'h0, err_line, motion_ok}, 32'h1);
    idle(HOLD + 5);
    chk1(err_line, 1'b0);
    wr(mci_pkg::ADDR_CTRL, 32'h0000_0000);
    cmd(8'h8f, 32'h0);
    chk({30'h0, soft_stop, err_line}, 32'h2);
    wr(mci_pkg::ADDR_CTRL, 32'h0000_0011);
    cmd(8'h8f, 32'h0);
    chk({30'h0, soft_stop, err_line}, 32'h2);
    for (int m = 2; m <= 6; m += 2) begin
      wr(mci_pkg::ADDR_CTRL, 32'h10 | 32'(m));
      @(posedge sys_clk) input_neutral <= 1'b0;
      cmd(8'h8f, 32'h0);
      chk({30'h0, soft_stop, err_line}, 32'h3);
      cmd(8'h83, 32'h0);
      chk1(err_line, 1'b1);
      @(posedge sys_clk) input_neutral <= 1'b1;
      idle(3);
      chk1(err_line, 1'b0);
    end
  endtask

  task automatic t_tmo();
    wr(mci_pkg::ADDR_CTRL, 32'h0000_0030);
    for (int i = 0; i < 4; i++) begin
      idle(30);
      cmd(8'h8c, 32'h0);
      chk1(err_line, 1'b0);
    end
    idle(TMO + 5);
    chk1(err_line, 1'b1);
    rd(mci_pkg::ADDR_STATUS);
    chk(q & 32'h0004_0000, 32'h0004_0000);
    cmd(8'h8c, 32'h0);
    chk1(err_line, 1'b0);
    wr(mci_pkg::ADDR_CTRL, 32'h0000_0010);
    cmd(8'h94, 32'h0);
    rd(mci_pkg::ADDR_IRQ_STAT);
    chk(q & 32'h8, 32'h0);
    cmd(8'h55, 32'h0);
    rd(mci_pkg::ADDR_IRQ_STAT);
    chk(q & 32'h8, 32'h8);
  endtask

  // ********************************
  // sequence
  // ********************************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_target();
    t_halt();
    t_deen();
    t_safe();
    t_tmo();
    stop_test();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end
endmodule
